// >>> fsg_pkg.sv
// package for the flash security option gate: map, fields, states, types
// assumes one 40 MHz clock domain and an AHB-Lite register bus
package fsg_pkg;
  localparam logic [15:0] FSG_ERASE_OPT_ADDR = 16'hfffa;
  localparam logic [15:0] FSG_DEBUG_OPT_ADDR = 16'hfffb;
  localparam logic [15:0] FSG_BLANK_FIRST = 16'hffe0;
  localparam logic [4:0] FSG_BLANK_LAST_IDX = 5'h1f;
  localparam logic [7:0] FSG_BYPASS_VAL = 8'hff;
  localparam logic [7:0] FSG_CMD_ERASE = 8'hf0;

  localparam logic [7:0] FSG_OFF_CTRL = 8'h00;
  localparam logic [7:0] FSG_OFF_REQ = 8'h04;
  localparam logic [7:0] FSG_OFF_STAT = 8'h08;
  localparam logic [7:0] FSG_OFF_IRQ = 8'h0c;
  localparam logic [7:0] FSG_OFF_MASK = 8'h10;
  localparam logic [7:0] FSG_OFF_OPT = 8'h14;

  // request register fields
  localparam int FSG_REQ_CMD_LSB = 0;
  localparam int FSG_REQ_DEBUG = 8;
  localparam int FSG_REQ_SECTOR = 9;
  localparam int FSG_REQ_PW_OK = 10;
  localparam int FSG_REQ_ADDR_OK = 11;
  localparam int FSG_REQ_GO = 31;

  // irq bits: 0 granted, 1 denied, 2 idle entered
  localparam int FSG_IRQ_W = 3;
  localparam logic [FSG_IRQ_W-1:0] FSG_IRQ_RESET = 3'h0;

  localparam int FSG_RD_LAT = 1;

  typedef enum logic [5:0] {
    FSG_IDLE = 6'h01,
    FSG_RD_ERASE_OPT = 6'h02,
    FSG_RD_DEBUG_OPT = 6'h04,
    FSG_SCAN_BLANK = 6'h08,
    FSG_DECIDE = 6'h10,
    FSG_LOCKED = 6'h20
  } fsg_state_t;

  typedef struct packed {
    logic [7:0] cmd;
    logic debug;
    logic sector;
    logic pw_ok;
    logic addr_ok;
  } fsg_req_t;

  typedef struct packed {
    logic [7:0] erase_opt;
    logic [7:0] debug_opt;
    logic blank;
  } fsg_opt_t;
endpackage

// >>> fsg_decide.sv
// decision logic: grant or idle-lockout from request, options and modes
// assumes inputs held stable while the caller sits in its decide state
`timescale 1ns/1ps
module fsg_decide
  import fsg_pkg::*;
(
  input wire fsg_req_t req,
  input wire fsg_opt_t opt,
  input wire logic sec_prog_en,
  input wire logic parallel_mode,
  output logic grant,
  output logic lockout,
  output logic chip_erase
);
  logic erase_byp;
  logic debug_byp;
  logic is_erase;
  always_comb begin
    erase_byp = (opt.erase_opt == FSG_BYPASS_VAL); // RULE_01
    debug_byp = (opt.debug_opt == FSG_BYPASS_VAL);
    is_erase = (req.cmd == FSG_CMD_ERASE) && !req.debug;
    grant = 1'b0;
    lockout = 1'b0;
    chip_erase = 1'b0;
    if (parallel_mode) begin
      if (is_erase && !req.sector) begin
        grant = 1'b1; // RULE_11
        chip_erase = 1'b1;
      end else if (!is_erase && !req.debug) begin
        grant = !sec_prog_en; // RULE_12
      end
    end else if (req.debug) begin
      if (!debug_byp && sec_prog_en) begin
        lockout = 1'b1; // RULE_08
      end else begin
        grant = req.pw_ok; // RULE_07 RULE_09
        lockout = !req.pw_ok;
      end
    end else if (is_erase && erase_byp) begin
      // a blank part also has the bypass byte set, so sector erase locks
      if (req.sector) begin
        lockout = 1'b1; // RULE_04
      end else begin
        grant = req.addr_ok; // RULE_02
        chip_erase = req.addr_ok;
        lockout = !req.addr_ok;
      end
    end else if (opt.blank) begin
      grant = req.addr_ok; // RULE_14
      chip_erase = is_erase && !req.sector && req.addr_ok;
      lockout = !req.addr_ok;
    end else begin
      grant = req.pw_ok && req.addr_ok && !sec_prog_en; // RULE_03 RULE_05
      chip_erase = grant && is_erase && !req.sector;
      lockout = !grant;
    end
  end
endmodule

// >>> fsg_gate.sv
// Function
// (RULE_01) erase bypass byte at 0xfffa, 0xff bypasses
// (RULE_02) bypass: erase checks addresses only
// (RULE_03) otherwise erase needs password and addresses
// (RULE_04) sector erase under bypass goes idle
// (RULE_05) other commands always need password; a blank device grants them on addresses alone
// (RULE_06) debug bypass byte read at 0xfffb
// (RULE_07) debug bypass skips security check, needs password
// (RULE_08) no bypass, security on: debug locks idle
// (RULE_09) no bypass, security off: password suffices
// (RULE_10) lockout recovered by external chip erase
// (RULE_11) parallel mode: chip erase always accepted
// (RULE_12) parallel mode, security off: free reads
// (RULE_13) production firmware should not set bypass
// (RULE_14) all ones 0xffe0..0xffff means blank device
// (RULE_15) idle left only by external reset
// (RULE_16) option bytes sampled on every evaluation
//
// flash security option gate with AHB-Lite registers
// assumes a flash read port with fixed one-cycle latency
//
// Local design decisions: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
module fsg_gate
  import fsg_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic [15:0] flash_addr,
  output logic flash_rd,
  input wire logic [7:0] flash_data,
  input wire logic sec_prog_en,
  input wire logic parallel_mode,
  output logic grant,
  output logic chip_erase,
  output logic idle_lock,
  output logic irq
);
  typedef struct packed {
    fsg_state_t st;
    logic ph_act;
    logic ph_wr;
    logic [7:0] ph_off;
    logic [31:0] rdata;
    fsg_req_t req;
    fsg_opt_t opt;
    logic [4:0] idx;
    logic [15:0] faddr;
    logic frd;
    logic rd_pend;
    logic grant;
    logic chip_erase;
    logic lock;
    logic busy;
    logic [FSG_IRQ_W-1:0] sts;
    logic [FSG_IRQ_W-1:0] mask;
    logic irq;
    logic sec_halt;
  } fsg_regs_t;

  fsg_regs_t r;
  fsg_regs_t next_r;
  logic d_grant;
  logic d_lock;
  logic d_ce;
  logic wr_req;
  logic wr_ctrl;
  logic [FSG_IRQ_W-1:0] ev;
  logic [31:0] wd;

  fsg_decide u_dec (
    .req(r.req),
    .opt(r.opt),
    .sec_prog_en(sec_prog_en),
    .parallel_mode(parallel_mode),
    .grant(d_grant),
    .lockout(d_lock),
    .chip_erase(d_ce)
  );

  always_comb begin
    next_r = r;
    ev = '0;
    wd = hwdata;
    wr_req = r.ph_act && r.ph_wr && (r.ph_off == FSG_OFF_REQ);
    wr_ctrl = r.ph_act && r.ph_wr && (r.ph_off == FSG_OFF_CTRL);
    next_r.grant = 1'b0;
    next_r.chip_erase = 1'b0;
    next_r.frd = 1'b0;
    next_r.rd_pend = r.frd;
    // address phase capture; single cycle wait-free slave
    next_r.ph_act = hsel && hready && htrans[1];
    next_r.ph_wr = hwrite;
    next_r.ph_off = haddr[7:0];
    if (hsel && hready && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        FSG_OFF_CTRL: next_r.rdata = {31'h0, r.sec_halt};
        FSG_OFF_REQ: next_r.rdata = {20'h0, r.req.addr_ok, r.req.pw_ok,
          r.req.sector, r.req.debug, r.req.cmd};
        FSG_OFF_STAT: next_r.rdata = {26'h0, r.st};
        FSG_OFF_IRQ: next_r.rdata = {29'h0, r.sts};
        FSG_OFF_MASK: next_r.rdata = {29'h0, r.mask};
        FSG_OFF_OPT: next_r.rdata = {15'h0, r.opt};
        default: next_r.rdata = 32'h0;
      endcase
    end
    if (wr_ctrl) begin
      next_r.sec_halt = wd[0];
    end
    if (r.ph_act && r.ph_wr && (r.ph_off == FSG_OFF_MASK)) begin
      next_r.mask = wd[FSG_IRQ_W-1:0];
    end
    case (r.st)
      FSG_IDLE: begin
        if (wr_req && wd[FSG_REQ_GO] && !r.sec_halt) begin
          next_r.req.cmd = wd[FSG_REQ_CMD_LSB +: 8];
          next_r.req.debug = wd[FSG_REQ_DEBUG];
          next_r.req.sector = wd[FSG_REQ_SECTOR];
          next_r.req.pw_ok = wd[FSG_REQ_PW_OK];
          next_r.req.addr_ok = wd[FSG_REQ_ADDR_OK];
          next_r.faddr = FSG_ERASE_OPT_ADDR; // RULE_16
          next_r.frd = 1'b1;
          next_r.busy = 1'b1;
          next_r.st = FSG_RD_ERASE_OPT;
        end
      end
      FSG_RD_ERASE_OPT: begin
        if (r.rd_pend) begin
          next_r.opt.erase_opt = flash_data; // RULE_01
          next_r.faddr = FSG_DEBUG_OPT_ADDR; // RULE_06
          next_r.frd = 1'b1;
          next_r.st = FSG_RD_DEBUG_OPT;
        end
      end
      FSG_RD_DEBUG_OPT: begin
        if (r.rd_pend) begin
          next_r.opt.debug_opt = flash_data; // RULE_06
          next_r.opt.blank = 1'b1;
          next_r.idx = 5'h0;
          next_r.faddr = FSG_BLANK_FIRST;
          next_r.frd = 1'b1;
          next_r.st = FSG_SCAN_BLANK;
        end
      end
      FSG_SCAN_BLANK: begin
        if (r.rd_pend) begin
          if (flash_data != FSG_BYPASS_VAL) begin
            next_r.opt.blank = 1'b0; // RULE_14
          end
          if (r.idx == FSG_BLANK_LAST_IDX) begin
            next_r.st = FSG_DECIDE;
          end else begin
            next_r.idx = r.idx + 5'h1;
            next_r.faddr = r.faddr + 16'h1;
            next_r.frd = 1'b1;
          end
        end
      end
      FSG_DECIDE: begin
        next_r.busy = 1'b0;
        if (d_lock) begin
          next_r.lock = 1'b1; // RULE_04 RULE_08
          next_r.st = FSG_LOCKED;
          ev[1] = 1'b1;
          ev[2] = 1'b1;
        end else begin
          next_r.grant = d_grant;
          next_r.chip_erase = d_ce; // RULE_11
          next_r.st = FSG_IDLE;
          ev[0] = d_grant;
          ev[1] = !d_grant;
        end
      end
      FSG_LOCKED: begin
        next_r.st = FSG_LOCKED; // RULE_15
      end
      default: begin
        next_r.st = FSG_IDLE;
      end
    endcase
    // write-one-to-clear, set wins
    if (r.ph_act && r.ph_wr && (r.ph_off == FSG_OFF_IRQ)) begin
      next_r.sts = (r.sts & ~wd[FSG_IRQ_W-1:0]) | ev;
    end else begin
      next_r.sts = r.sts | ev;
    end
    next_r.irq = |(next_r.sts & next_r.mask);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '{st: FSG_IDLE, ph_off: 8'h0, rdata: 32'h0, req: '0, opt: '0,
        idx: 5'h0, faddr: 16'h0, sts: FSG_IRQ_RESET, mask: FSG_IRQ_RESET,
        default: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign hrdata = r.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign flash_addr = r.faddr;
  assign flash_rd = r.frd;
  assign grant = r.grant;
  assign chip_erase = r.chip_erase;
  assign idle_lock = r.lock;
  assign irq = r.irq;

  sector_lock_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (r.st == FSG_DECIDE && !parallel_mode && !r.opt.blank
     && r.req.cmd == FSG_CMD_ERASE && !r.req.debug && r.req.sector
     && r.opt.erase_opt == FSG_BYPASS_VAL) |=> idle_lock) // RULE_04
    else $error("sector erase under bypass not locked");
  debug_lock_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (r.st == FSG_DECIDE && !parallel_mode && r.req.debug && sec_prog_en
     && r.opt.debug_opt != FSG_BYPASS_VAL) |=> idle_lock && !grant) // RULE_08
    else $error("secured debug start not locked");
  debug_pw_a: assert property (@(posedge hclk) disable iff (!hresetn)
    grant && $past(r.req.debug) |-> $past(r.req.pw_ok)) // RULE_07
    else $error("debug granted without password");
  other_pw_a: assert property (@(posedge hclk) disable iff (!hresetn)
    grant && $past(r.req.cmd) != FSG_CMD_ERASE && !$past(parallel_mode)
    && !$past(r.opt.blank) |-> $past(r.req.pw_ok)) // RULE_05
    else $error("command granted without password");
  par_erase_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (r.st == FSG_DECIDE && parallel_mode && r.req.cmd == FSG_CMD_ERASE
     && !r.req.debug && !r.req.sector) |=> grant && chip_erase) // RULE_11
    else $error("parallel chip erase refused");
  opt_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    r.st == FSG_IDLE ##1 r.st == FSG_RD_ERASE_OPT
    |-> flash_rd && flash_addr == FSG_ERASE_OPT_ADDR) // RULE_16
    else $error("erase option byte not read");
  dbg_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(r.st == FSG_RD_DEBUG_OPT)
    |-> flash_rd && flash_addr == FSG_DEBUG_OPT_ADDR) // RULE_06
    else $error("debug option byte not read");
  lock_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    idle_lock |=> idle_lock [*4]) // RULE_15
    else $error("lockout released without reset");
  blank_a: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(r.st == FSG_DECIDE) && $past(flash_data) != FSG_BYPASS_VAL
    |-> !r.opt.blank) // RULE_14
    else $error("blank flag wrong");
  irq_lvl_a: assert property (@(posedge hclk) disable iff (!hresetn)
    irq == |(r.sts & r.mask))
    else $error("interrupt level wrong");
  grant_c: cover property (@(posedge hclk) disable iff (!hresetn) grant);
  lock_c: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(idle_lock));
  ce_c: cover property (@(posedge hclk) disable iff (!hresetn) chip_erase);
endmodule

// >>> fsg_flash_model.sv
// flash read port model for the option gate bench
// assumes a one-cycle read latency; data drifts when not read
`timescale 1ns/1ps
module fsg_flash_model (
  input wire logic hclk,
  input wire logic [15:0] flash_addr,
  input wire logic flash_rd,
  output logic [7:0] flash_data
);
  // top 32 bytes, 0xffe0..0xffff, filled by the bench
  logic [7:0] mem [0:31];
  initial flash_data = 8'h00;
  // stale bytes are inverted, never held
  always @(posedge hclk) begin
    if (flash_rd)
      flash_data <= mem[flash_addr[4:0]];
    else
      flash_data <= ~flash_data;
  end
endmodule

// >>> flash_security_option_gate_tb_top.sv
// testbench for the flash security option gate, checked against a model
// assumes fsg_gate, fsg_pkg and fsg_flash_model are compiled first
`timescale 1ns/1ps
module flash_security_option_gate_tb_top;
  import fsg_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, flash_rd;
  logic sec_prog_en, parallel_mode, grant, chip_erase, idle_lock, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] flash_addr;
  logic [7:0] flash_data;
  logic [31:0] msk;
  int err_total, checks_done, n_grant, n_chip;
  logic [7:0] cmds [5] = '{8'hf0, 8'h30, 8'h40, 8'h60, 8'hfa};

  always #12.5 hclk = ~hclk;

  fsg_gate uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .flash_addr(flash_addr), .flash_rd(flash_rd),
    .flash_data(flash_data), .sec_prog_en(sec_prog_en),
    .parallel_mode(parallel_mode), .grant(grant), .chip_erase(chip_erase),
    .idle_lock(idle_lock), .irq(irq));
  fsg_flash_model flash (.hclk(hclk), .flash_addr(flash_addr),
    .flash_rd(flash_rd), .flash_data(flash_data));

  always @(posedge hclk) begin
    if (grant === 1'b1) n_grant++;
    if (chip_erase === 1'b1) n_chip++;
  end

  task automatic wrap_up;
    if (err_total == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t reg got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t pin got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 90);
    rd = hrdata;
    if (n >= 50) begin
      err_total++;
      wrap_up();
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bus(1'b0, a, 32'h0, d);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] x;
    bus(1'b1, a, v, x);
  endtask

  task automatic do_reset;
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
  endtask

  // {chip erase, lockout, denied, granted}
  function automatic logic [3:0] model(logic [7:0] c, logic dbg, se, pw, ad,
      logic [7:0] eo, doo, logic bl, sp, pa);
    logic er;
    er = (c == FSG_CMD_ERASE);
    if (pa) begin
      if (er && !dbg) return se ? 4'h2 : 4'h9;
      return (sp || dbg) ? 4'h2 : 4'h1;
    end
    // a lockout also reports the request as denied
    if (dbg) return ((doo != FSG_BYPASS_VAL && sp) || !pw) ? 4'h6 : 4'h1;
    if (er && eo == FSG_BYPASS_VAL) return (se || !ad) ? 4'h6 : 4'h9;
    return (ad && (bl || (pw && !sp))) ? {er && !se, 3'h1} : 4'h6;
  endfunction

  task automatic run(input logic [7:0] c, input logic dbg, se, pw, ad,
      input logic [7:0] eo, doo, input logic sp, pa);
    logic [31:0] d;
    logic [3:0] e;
    logic bl;
    int g0, c0, n;
    flash.mem[26] = eo;
    flash.mem[27] = doo;
    bl = 1'b1;
    for (n = 0; n < 32; n++) bl &= (flash.mem[n] == 8'hff);
    sec_prog_en <= sp;
    parallel_mode <= pa;
    e = model(c, dbg, se, pw, ad, eo, doo, bl, sp, pa);
    wr(FSG_OFF_MASK, msk);
    g0 = n_grant;
    c0 = n_chip;
    wr(FSG_OFF_REQ, {1'b1, 19'h0, ad, pw, se, dbg, c});
    d = 32'h0;
    for (n = 0; n < 100 && d[2:0] === 3'h0; n++) rd(FSG_OFF_IRQ, d);
    if (d[2:0] === 3'h0) begin
      err_total++;
      wrap_up();
    end
    chk_pin(hresp, 1'b0);
    chk_reg(d, {29'h0, e[2:0]});
    chk_reg(n_grant - g0, {31'h0, e[0]});
    chk_reg(n_chip - c0, {31'h0, e[3]});
    chk_pin(idle_lock, e[2]);
    chk_pin(irq, msk[2:0] != 3'h0);
    rd(FSG_OFF_OPT, d);
    chk_reg(d, {15'h0, eo, doo, bl});
    rd(FSG_OFF_STAT, d);
    chk_reg(d, e[2] ? 32'h20 : 32'h01);
    wr(FSG_OFF_IRQ, 32'h7);
    rd(FSG_OFF_IRQ, d);
    chk_reg(d, 32'h0);
    chk_pin(irq, 1'b0);
    if (e[2]) begin
      // a locked gate takes no further request
      wr(FSG_OFF_REQ, {1'b1, 19'h0, 4'h1, c});
      for (n = 0; n < 40; n++) rd(FSG_OFF_IRQ, d);
      chk_reg(d, 32'h0);
      chk_pin(idle_lock, 1'b1);
      do_reset();
    end
  endtask

  initial begin
    logic [31:0] d;
    logic [7:0] c, eo, doo;
    logic pa;
    hclk = 0;
    hresetn = 0;
    hsel = 0;
    haddr = 0;
    htrans = 0;
    hwrite = 0;
    hsize = 3'h2;
    hwdata = 0;
    sec_prog_en = 0;
    parallel_mode = 0;
    msk = 0;
    for (int i = 0; i < 32; i++) flash.mem[i] = 8'hff;
    flash.mem[0] = 8'h00;
    void'($urandom(65503));
    do_reset();
    rd(FSG_OFF_STAT, d);
    chk_reg(d, 32'h01);
    rd(8'h20, d);
    chk_reg(d, 32'h0);
    run(8'hf0, 0, 0, 0, 1, 8'hff, 8'h00, 0, 0);
    msk = 32'h7;
    run(8'hf0, 0, 1, 1, 1, 8'hff, 8'h00, 0, 0);
    run(8'hf0, 0, 0, 1, 0, 8'hff, 8'h00, 0, 0);
    run(8'hf0, 0, 0, 0, 1, 8'h5a, 8'h00, 0, 0);
    run(8'h40, 0, 0, 0, 1, 8'hff, 8'h00, 0, 0);
    run(8'h00, 1, 0, 0, 1, 8'h00, 8'hff, 1, 0);
    run(8'h00, 1, 0, 1, 1, 8'h00, 8'hff, 1, 0);
    run(8'h00, 1, 0, 1, 1, 8'h00, 8'h00, 1, 0);
    run(8'hf0, 0, 0, 1, 1, 8'hff, 8'h00, 1, 0);
    run(8'h00, 1, 0, 1, 1, 8'h00, 8'h00, 0, 0);
    run(8'hf0, 0, 0, 0, 0, 8'h00, 8'h00, 1, 1);
    run(8'h40, 0, 0, 0, 0, 8'h00, 8'h00, 0, 1);
    run(8'h40, 0, 0, 0, 0, 8'h00, 8'h00, 1, 1);
    flash.mem[0] = 8'hff;
    run(8'hf0, 0, 0, 0, 1, 8'hff, 8'hff, 0, 0);
    run(8'h30, 0, 0, 0, 1, 8'hff, 8'hff, 0, 0);
    for (int k = 0; k < 8; k++) begin
      flash.mem[0] = $urandom_range(1) ? 8'hff : 8'h00;
      c = cmds[$urandom_range(4)];
      pa = 1'($urandom_range(1));
      eo = $urandom_range(1) ? 8'hff : 8'($urandom_range(254));
      doo = $urandom_range(1) ? 8'hff : 8'($urandom_range(254));
      run(c, 0, (c == 8'hf0) & 1'($urandom_range(1)), 1'($urandom_range(1)),
          1'($urandom_range(1)), eo, doo, pa & 1'($urandom_range(1)), pa);
    end
    wrap_up();
  end
endmodule
